// ---- src/link_deskew_consts.svh ----
`ifndef LINK_DESKEW_CONSTS_SVH
`define LINK_DESKEW_CONSTS_SVH

`define LANES           8
`define LANE_BITS       7
`define DATA_BITS       6

`define CTRL_OFFSET     8'h00
`define RATE_OFFSET     8'h04
`define STATUS_OFFSET   8'h08
`define COARSE_OFFSET   8'h0C
`define FINE_OFFSET     8'h10

`define CTRL_SCHEME_BIT 0
`define CTRL_DCBAL_BIT  1
`define CTRL_START_BIT  2
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define STAT_TXBLK_BIT  2

`define SCHEME_RESET    1'h1
`define DCBAL_RESET     1'h1
`define RATE_RESET      8'h85
`define TX_MAX_RATE_MHZ 8'h50

`define RX_CAL_CYCLES   13'h1000
`define RX_CAL_LAST     (`RX_CAL_CYCLES - 13'h0001)
`define TX_CAL_CYCLES   13'h0100
`define TX_CAL_LAST     (`TX_CAL_CYCLES - 13'h0001)
`define FINE_STEP_MASK  8'hFF

`define FINE_RANGE_PS   200
`define FINE_STEP_PS    50
`define FINE_MAX_STEPS  (`FINE_RANGE_PS / `FINE_STEP_PS)

`define DESKEW_PATTERN  7'h71
`define COARSE_ZERO     2'h0
`define COARSE_PLUS     2'h1
`define COARSE_MINUS    2'h3

`endif

// ---- src/link_deskew_pkg.sv ----
package link_deskew_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CALIB_RX,
        ST_CALIB_TX
    } cal_state_type;

endpackage

// ---- src/sync_2ff.sv ----
`timescale 1ns/10ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input  wire logic             clk,
    input  wire logic             rst_n,
    // level from another domain
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// ---- src/deskew_lane.sv ----
`timescale 1ns/10ps
`include "link_deskew_consts.svh"
module deskew_lane import link_deskew_pkg::*; (
    // link clock domain
    input  wire logic       clk,
    input  wire logic       rst_n,
    // lane word and phase detector
    input  wire logic [6:0] lane_word,
    input  wire logic       early,
    input  wire logic       late,
    // calibration control
    input  wire logic       clear,
    input  wire logic       measure,
    input  wire logic       step,
    input  wire logic       commit,
    input  wire logic       use_fine,
    // results
    output logic            switching,
    output logic            pattern_hit,
    output logic [1:0]      coarse_q,
    output logic [3:0]      fine_q,
    output logic [5:0]      aligned_q
);

    localparam logic signed [3:0] FINE_MAX = 4'(`FINE_MAX_STEPS);

    logic [6:0]        w1_q;
    logic [6:0]        w2_q;
    logic [8:0]        window;
    logic [6:0]        cand_zero;
    logic [6:0]        cand_minus;
    logic [6:0]        cand_plus;
    logic              miss_zero_q;
    logic              miss_minus_q;
    logic              miss_plus_q;
    logic [1:0]        coarse_pick;
    logic signed [3:0] fine_work_q;
    logic signed [9:0] bal_q;
    logic [6:0]        sel;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w1_q <= 7'h00;
            w2_q <= 7'h00;
        end else begin
            w1_q <= lane_word;
            w2_q <= w1_q;
        end
    end

    // one bit either side of the word under test
    assign window     = {w2_q[0], w1_q, lane_word[6]};
    assign cand_zero  = window[7:1];
    assign cand_minus = window[8:2];
    assign cand_plus  = window[6:0];
    assign switching  = |({w2_q[0], w1_q[6:1]} ^ w1_q);
    assign pattern_hit = (cand_zero == `DESKEW_PATTERN) ||
                         (cand_minus == `DESKEW_PATTERN) ||
                         (cand_plus == `DESKEW_PATTERN);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            miss_zero_q  <= 1'b0;
            miss_minus_q <= 1'b0;
            miss_plus_q  <= 1'b0;
        end else if (clear) begin
            miss_zero_q  <= 1'b0;
            miss_minus_q <= 1'b0;
            miss_plus_q  <= 1'b0;
        end else if (measure && !use_fine) begin
            miss_zero_q  <= miss_zero_q | (cand_zero != `DESKEW_PATTERN);
            miss_minus_q <= miss_minus_q | (cand_minus != `DESKEW_PATTERN);
            miss_plus_q  <= miss_plus_q | (cand_plus != `DESKEW_PATTERN);
        end
    end

    // beyond one bit no candidate holds, so no shift is applied
    always_comb begin
        if (!miss_zero_q) begin
            coarse_pick = `COARSE_ZERO;
        end else if (!miss_minus_q) begin
            coarse_pick = `COARSE_MINUS;
        end else if (!miss_plus_q) begin
            coarse_pick = `COARSE_PLUS;
        end else begin
            coarse_pick = `COARSE_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fine_work_q <= 4'sh0;
            bal_q       <= 10'sh000;
        end else if (clear) begin
            fine_work_q <= fine_q;
            bal_q       <= 10'sh000;
        end else if (measure && use_fine && step) begin
            bal_q <= 10'sh000;
            if (bal_q > 10'sh000 && fine_work_q < FINE_MAX) begin
                fine_work_q <= fine_work_q + 4'sh1;
            end else if (bal_q < 10'sh000 && fine_work_q > -FINE_MAX) begin
                fine_work_q <= fine_work_q - 4'sh1;
            end
        end else if (measure && use_fine && (late != early)) begin
            bal_q <= late ? bal_q + 10'sh001 : bal_q - 10'sh001;
        end
    end

    // results move only at commit and hold until the next one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coarse_q <= `COARSE_ZERO;
            fine_q   <= 4'h0;
        end else if (commit) begin
            if (use_fine) begin
                fine_q <= fine_work_q;
            end else begin
                coarse_q <= coarse_pick;
            end
        end
    end

    always_comb begin
        case (coarse_q)
            `COARSE_PLUS:  sel = cand_plus;
            `COARSE_MINUS: sel = cand_minus;
            default:       sel = cand_zero;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aligned_q <= 6'h00;
        end else begin
            aligned_q <= sel[5:0];
        end
    end

endmodule

// ---- src/link_pair_deskew_control.sv ----
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`include "link_deskew_consts.svh"
module link_pair_deskew_control import link_deskew_pkg::*; (
    // ahb-lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // link side, forwarded parallel clock
    input  wire logic        rx_link_clk,
    input  wire logic [55:0] lane_word,
    input  wire logic [7:0]  lane_early,
    input  wire logic [7:0]  lane_late,
    // pins
    input  wire logic        power_down_n,
    input  wire logic        deskew_enable,
    // results
    output logic [47:0]      receiver_parallel_data_out,
    output logic [15:0]      coarse_tap,
    output logic [31:0]      fine_tap,
    output logic             deskew_busy
);

    // bus side state
    logic        addr_valid_q;
    logic        addr_write_q;
    logic [7:0]  addr_q;
    logic        wr_en;
    logic        rd_req;
    logic [31:0] rd_mux;
    logic        scheme_rx_q;
    logic        dc_balance_q;
    logic [7:0]  rate_q;
    logic        start_tgl_q;
    logic        tx_ok_q;
    logic [1:0]  stat_s;
    logic        done_seen_q;
    logic [47:0] taps_s;
    logic [15:0] coarse_hold_q;
    logic [31:0] fine_hold_q;

    // link side state
    logic          link_rst_n;
    logic [4:0]    in_s;
    logic          pd_s;
    logic          en_s;
    logic          scheme_s;
    logic          tx_ok_s;
    logic          tgl_s;
    logic          pd_d_q;
    logic          en_d_q;
    logic          tgl_d_q;
    logic          trig_rx;
    logic          tx_start;
    logic          clear;
    logic          commit;
    logic          measure;
    logic          step;
    logic          use_fine;
    logic          all_switch;
    logic          all_hit;
    logic [7:0]    lane_switch;
    logic [7:0]    lane_hit;
    cal_state_type state_q;
    logic [12:0]   cnt_q;
    logic          done_q;

    // ---------------- bus slave ----------------

    // word accesses only; hsize is not decoded
    assign rd_req = hready && hsel && htrans[1] && !hwrite;
    assign wr_en  = addr_valid_q && addr_write_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_valid_q <= 1'b0;
            addr_write_q <= 1'b0;
            addr_q       <= 8'h00;
        end else if (hready) begin
            addr_valid_q <= hsel && htrans[1];
            addr_write_q <= hwrite;
            addr_q       <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scheme_rx_q  <= `SCHEME_RESET;
            dc_balance_q <= `DCBAL_RESET;
            rate_q       <= `RATE_RESET;
            start_tgl_q  <= 1'b0;
        end else if (wr_en && addr_q == `CTRL_OFFSET) begin
            scheme_rx_q  <= hwdata[`CTRL_SCHEME_BIT];
            dc_balance_q <= hwdata[`CTRL_DCBAL_BIT];
            if (hwdata[`CTRL_START_BIT]) begin
                start_tgl_q <= !start_tgl_q;
            end
        end else if (wr_en && addr_q == `RATE_OFFSET) begin
            rate_q <= hwdata[7:0];
        end
    end

    // pattern scheme allowed only at low rate and with balance coding
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_ok_q <= 1'b0;
        end else begin
            tx_ok_q <= dc_balance_q &&
                       (rate_q <= `TX_MAX_RATE_MHZ);
        end
    end

    sync_2ff #(.WIDTH(2)) u_stat_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({done_q, deskew_busy}),
        .q     (stat_s)
    );

    // taps are static once done is high; sampled only then
    sync_2ff #(.WIDTH(48)) u_tap_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({coarse_tap, fine_tap}),
        .q     (taps_s)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_seen_q   <= 1'b0;
            coarse_hold_q <= 16'h0000;
            fine_hold_q   <= 32'h0000_0000;
        end else begin
            done_seen_q <= stat_s[1];
            if (stat_s[1] && done_seen_q) begin
                coarse_hold_q <= taps_s[47:32];
                fine_hold_q   <= taps_s[31:0];
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `CTRL_OFFSET: begin
                rd_mux[`CTRL_SCHEME_BIT] = scheme_rx_q;
                rd_mux[`CTRL_DCBAL_BIT]  = dc_balance_q;
            end
            `RATE_OFFSET: begin
                rd_mux[7:0] = rate_q;
            end
            `STATUS_OFFSET: begin
                rd_mux[`STAT_BUSY_BIT]  = stat_s[0];
                rd_mux[`STAT_DONE_BIT]  = stat_s[1];
                rd_mux[`STAT_TXBLK_BIT] = !tx_ok_q;
            end
            `COARSE_OFFSET: begin
                rd_mux[15:0] = coarse_hold_q;
            end
            `FINE_OFFSET: begin
                rd_mux = fine_hold_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_req) begin
            hrdata <= rd_mux;
        end else if (hready) begin
            hrdata <= 32'h0000_0000;
        end
    end

    // ---------------- link domain ----------------

    sync_2ff #(.WIDTH(1)) u_rst_sync (
        .clk   (rx_link_clk),
        .rst_n (hresetn),
        .d     (1'b1),
        .q     (link_rst_n)
    );

    sync_2ff #(.WIDTH(5)) u_in_sync (
        .clk   (rx_link_clk),
        .rst_n (link_rst_n),
        .d     ({power_down_n, deskew_enable, scheme_rx_q, tx_ok_q,
                 start_tgl_q}),
        .q     (in_s)
    );

    assign pd_s     = in_s[4];
    assign en_s     = in_s[3];
    assign scheme_s = in_s[2];
    assign tx_ok_s  = in_s[1];
    assign tgl_s    = in_s[0];

    always_ff @(posedge rx_link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            pd_d_q  <= 1'b0;
            en_d_q  <= 1'b0;
            tgl_d_q <= 1'b0;
        end else begin
            pd_d_q  <= pd_s;
            en_d_q  <= en_s;
            tgl_d_q <= tgl_s;
        end
    end

    // power-up, pin toggle or software start, in self-calibrating mode
    assign trig_rx = scheme_s && pd_s &&
                     ((pd_s && !pd_d_q) ||
                      (en_s != en_d_q) ||
                      (tgl_s != tgl_d_q));

    // serializer pattern seen on every lane while enable is high
    assign tx_start = (state_q == ST_IDLE) && !scheme_s && tx_ok_s &&
                      en_s && pd_s && all_hit;

    assign all_switch = &lane_switch;
    assign all_hit    = &lane_hit;
    assign clear      = trig_rx || tx_start;
    assign use_fine   = (state_q == ST_CALIB_RX);
    assign measure    = (state_q != ST_IDLE) && !clear;
    assign step       = use_fine && all_switch &&
                        (cnt_q[7:0] == `FINE_STEP_MASK);
    assign commit     = !clear &&
                        (((state_q == ST_CALIB_RX) && pd_s && all_switch &&
                          (cnt_q == `RX_CAL_LAST)) ||
                         ((state_q == ST_CALIB_TX) && pd_s && en_s &&
                          tx_ok_s && all_hit &&
                          (cnt_q == `TX_CAL_LAST)));

    always_ff @(posedge rx_link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= 13'h0000;
        end else if (trig_rx) begin
            state_q <= ST_CALIB_RX;
            cnt_q   <= 13'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 13'h0000;
                    if (tx_start) begin
                        state_q <= ST_CALIB_TX;
                    end
                end
                ST_CALIB_RX: begin
                    if (!pd_s) begin
                        state_q <= ST_IDLE;
                    end else if (!all_switch) begin
                        cnt_q <= 13'h0000;
                    end else if (commit) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 13'h0001;
                    end
                end
                ST_CALIB_TX: begin
                    // pattern lasts as long as the request is held low
                    if (!pd_s || !en_s || !tx_ok_s || !all_hit) begin
                        state_q <= ST_IDLE;
                    end else if (commit) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 13'h0001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q   <= 13'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge rx_link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            done_q      <= 1'b0;
            deskew_busy <= 1'b0;
        end else begin
            deskew_busy <= clear || (measure && !commit && pd_s);
            if (clear) begin
                done_q <= 1'b0;
            end else if (commit) begin
                done_q <= 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `LANES; g++) begin : g_lane
            deskew_lane u_lane (
                .clk         (rx_link_clk),
                .rst_n       (link_rst_n),
                .lane_word   (lane_word[g*`LANE_BITS +: `LANE_BITS]),
                .early       (lane_early[g]),
                .late        (lane_late[g]),
                .clear       (clear),
                .measure     (measure),
                .step        (step),
                .commit      (commit),
                .use_fine    (use_fine),
                .switching   (lane_switch[g]),
                .pattern_hit (lane_hit[g]),
                .coarse_q    (coarse_tap[g*2 +: 2]),
                .fine_q      (fine_tap[g*4 +: 4]),
                .aligned_q   (receiver_parallel_data_out[g*`DATA_BITS +:
                                                         `DATA_BITS])
            );
        end
    endgenerate

endmodule

// ---- dv/link_pair_deskew_control_props.sv ----
`timescale 1ns/10ps
module deskew_props (
    // link domain
    input wire logic        rx_link_clk,
    input wire logic        hresetn,
    // pins and results
    input wire logic        power_down_n,
    input wire logic        deskew_enable,
    input wire logic [15:0] coarse_tap,
    input wire logic [31:0] fine_tap,
    input wire logic        deskew_busy
);
    logic [12:0] busy_cnt_q;

    default clocking @(posedge rx_link_clk); endclocking
    default disable iff (!hresetn);

    // saturates so a chain of restarts cannot wrap
    always_ff @(posedge rx_link_clk or negedge hresetn) begin
        if (!hresetn)
            busy_cnt_q <= 13'h0000;
        else if (!deskew_busy)
            busy_cnt_q <= 13'h0000;
        else if (busy_cnt_q != 13'h1FFF)
            busy_cnt_q <= busy_cnt_q + 13'h0001;
    end

    function automatic logic fine_ok(input logic [31:0] f);
        logic ok;
        ok = 1'b1;
        for (int g = 0; g < 8; g++) begin
            if (f[4*g+3] ? f[4*g +: 4] < 4'hC : f[4*g +: 4] > 4'h4)
                ok = 1'b0;
        end
        return ok;
    endfunction

    a_taps_held: assert property (
        !deskew_busy && $past(!deskew_busy)
        |-> $stable(fine_tap) && $stable(coarse_tap))
        else $error("taps moved while idle");
    a_fine_range: assert property (fine_ok(fine_tap))
        else $error("fine tap out of range");
    a_coarse_codes: assert property (
        ((coarse_tap >> 1) & ~coarse_tap & 16'h5555) == 16'h0000)
        else $error("coarse tap code illegal");
    a_fine_after_cal: assert property (
        $changed(fine_tap) |-> busy_cnt_q >= 13'h0FF0)
        else $error("fine tap changed too early");
    a_coarse_needs_en: assert property (
        $changed(coarse_tap) |-> $past(deskew_enable, 8)
        && $past(power_down_n, 8) && busy_cnt_q >= 13'h00F0)
        else $error("coarse tap changed without enable");
    a_rise_starts_busy: assert property (
        $rose(deskew_enable) && power_down_n && $past(power_down_n, 4)
        |-> ##[1:8] deskew_busy)
        else $error("enable edge did not start deskew");
    a_powerup_cal: assert property (
        $rose(power_down_n) |-> ##[1:8] deskew_busy)
        else $error("no calibration at power-up");
    a_pd_abort: assert property (
        $fell(power_down_n) |-> ##[1:8] !deskew_busy)
        else $error("power-down did not abort");
endmodule

// ---- dv/serializer_model.sv ----
`timescale 1ns/10ps
module serializer_model (
    // forwarded parallel clock
    input  wire logic        clk,
    // controls from the bench
    input  wire logic        deskew_pattern_request_n,
    input  wire logic        run,
    // lanes as parallel words
    output logic      [55:0] lane_word
);
    logic [31:0] seed_q = 32'h00000061;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    always @(posedge clk) begin
        seed_q <= xorshift(seed_q);
        for (int g = 0; g < 8; g++) begin
            // rotated a bit: only a shifted alignment can match
            if (!deskew_pattern_request_n)
                lane_word[7*g +: 7] <= 7'h63;
            else if (run)
                lane_word[7*g +: 7] <= {2'h2, seed_q[3*g +: 5]};
            else
                lane_word[7*g +: 7] <= 7'h7F;
        end
    end
endmodule

// ---- dv/link_pair_deskew_control_test.sv ----
`timescale 1ns/10ps
module link_pair_deskew_control_test;
    logic        hclk = 1'b0;
    logic        rx_link_clk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [55:0] lane_word;
    logic [7:0]  lane_early = 8'h00;
    logic [7:0]  lane_late = 8'h00;
    logic        power_down_n = 1'b0;
    logic        deskew_enable = 1'b0;
    logic        deskew_pattern_request_n = 1'b1;
    logic        run = 1'b0;
    logic [47:0] receiver_parallel_data_out;
    logic [15:0] coarse_tap;
    logic [31:0] fine_tap;
    logic        deskew_busy;
    logic        dphase_q = 1'b0;
    logic [31:0] exp_q[$];
    int          num_errors = 0;
    int          samples_checked = 0;

    always #2.5 hclk = ~hclk;
    initial begin
        #1.3;
        forever #6 rx_link_clk = ~rx_link_clk;
    end

    link_pair_deskew_control u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata,
        .hreadyout, .hresp, .rx_link_clk, .lane_word, .lane_early,
        .lane_late, .power_down_n, .deskew_enable,
        .receiver_parallel_data_out, .coarse_tap, .fine_tap,
        .deskew_busy
    );
    serializer_model u_far (
        .clk(rx_link_clk), .deskew_pattern_request_n, .run, .lane_word
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // read data is taken at the edge ending the data phase
    always @(posedge hclk) begin
        if (dphase_q && hreadyout === 1'b1) begin
            chk(hrdata, exp_q.pop_front());
            chk({31'h0, hresp}, 32'h0);
        end
        dphase_q <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        if (!w)
            exp_q.push_back(d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        while (deskew_busy !== v && n < 20000) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, deskew_busy}, {31'h0, v});
    endtask

    initial begin
        #400us;
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        xfer(1'b0, 8'h00, 32'h3);
        xfer(1'b0, 8'h04, 32'h85);
        xfer(1'b0, 8'h08, 32'h4);
        xfer(1'b1, 8'h20, 32'hFFFFFFFF);
        xfer(1'b0, 8'h20, 32'h0);
        // clock already runs before power-down is released
        lane_late <= 8'h0F;
        lane_early <= 8'hF0;
        run <= 1'b1;
        repeat (20) @(posedge hclk);
        power_down_n <= 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (10) @(posedge hclk);
        xfer(1'b0, 8'h10, 32'hCCCC4444);
        xfer(1'b0, 8'h08, 32'h6);
        // idle lanes first: the count must not advance
        run <= 1'b0;
        lane_late <= 8'hF0;
        lane_early <= 8'h0F;
        deskew_enable <= 1'b1;
        wait_busy(1'b1);
        repeat (2000) @(posedge hclk);
        chk({31'h0, deskew_busy}, 32'h1);
        run <= 1'b1;
        wait_busy(1'b0);
        repeat (10) @(posedge hclk);
        xfer(1'b0, 8'h10, 32'h4444CCCC);
        xfer(1'b1, 8'h04, 32'h51);
        xfer(1'b1, 8'h00, 32'h2);
        repeat (2) @(posedge hclk);
        xfer(1'b0, 8'h08, 32'h6);
        xfer(1'b1, 8'h04, 32'h50);
        xfer(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge hclk);
        xfer(1'b0, 8'h08, 32'h6);
        xfer(1'b1, 8'h00, 32'h2);
        repeat (2) @(posedge hclk);
        xfer(1'b0, 8'h08, 32'h2);
        deskew_enable <= 1'b0;
        deskew_pattern_request_n <= 1'b0;
        repeat (2000) @(posedge hclk);
        chk({31'h0, deskew_busy}, 32'h0);
        deskew_enable <= 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (10) @(posedge hclk);
        // all lanes see the same one-bit shift
        chk({31'h0, (coarse_tap == {8{coarse_tap[1:0]}}) && coarse_tap[0]},
            32'h1);
        // minus shift of the pattern leaves its low six bits
        chk({31'h0, receiver_parallel_data_out == {8{6'h31}}}, 32'h1);
        xfer(1'b0, 8'h10, 32'h4444CCCC);
        // request stays low for another 40 us
        repeat (8000) @(posedge hclk);
        xfer(1'b0, 8'h0C, 32'hFFFF);
        deskew_pattern_request_n <= 1'b1;
        xfer(1'b1, 8'h00, 32'h7);
        xfer(1'b0, 8'h00, 32'h3);
        wait_busy(1'b1);
        repeat (200) @(posedge hclk);
        // still calibrating: busy set, done cleared by the restart
        xfer(1'b0, 8'h08, 32'h1);
        power_down_n <= 1'b0;
        wait_busy(1'b0);
        repeat (10) @(posedge hclk);
        xfer(1'b0, 8'h10, 32'h4444CCCC);
        xfer(1'b0, 8'h08, 32'h0);
        complete_run();
    end
endmodule

bind link_pair_deskew_control deskew_props u_props (
    .rx_link_clk, .hresetn, .power_down_n, .deskew_enable,
    .coarse_tap, .fine_tap, .deskew_busy
);
